// >>> pkg/periodic_tick_pkg.sv
// Purpose: Shared constants for the periodic tick unit and its register file
// Assumes: AXI4-Lite slave with 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses
package periodic_tick_pkg;

  localparam logic [4:0] off_drive_clock   = 5'h00;
  localparam logic [4:0] off_enable_period = 5'h04;
  localparam logic [4:0] off_status_ctrl   = 5'h08;
  localparam logic [4:0] off_irq_status    = 5'h0c;
  localparam logic [4:0] off_irq_enable    = 5'h10;
  localparam logic [4:0] off_irq_clear     = 5'h14;

  // Drive and clock register fields
  localparam int pos_pending    = 7;
  localparam int pos_drive_lo   = 2;
  localparam int pos_clksel_lo  = 0;
  // Enable and period register fields
  localparam int pos_period_lo  = 4;
  localparam int pos_kb_en_lo   = 0;
  // Status and control register fields
  localparam int pos_kb_flag    = 3;
  localparam int pos_ack        = 2;
  localparam int pos_kb_mask    = 1;
  localparam int pos_sens       = 0;

  localparam logic [3:0] rst_drive      = 4'h0;
  localparam logic [1:0] rst_clksel     = 2'h0;
  localparam logic [2:0] rst_period     = 3'h0;
  localparam logic [3:0] rst_kb_en      = 4'h0;
  localparam logic [1:0] rst_irq_enable = 2'h0;

  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Interrupt status bit positions
  localparam int ev_period  = 0;
  localparam int ev_keypad  = 1;
  localparam int num_events = 2;

  localparam int count_width = 15;

  typedef enum logic [1:0] {
    clk_internal_rc,
    clk_external_pin,
    clk_oscillator,
    clk_reserved
  } clock_select_e;

endpackage : periodic_tick_pkg

// >>> pkg/tick_source_if.sv
// Purpose: Carries the selected tick stream between the source selector and the counter
// Assumes: Single clock domain
// Notes:   tick is a one-cycle pulse per counted edge
interface tick_source_if;
  logic       tick;
  logic [1:0] select;

  modport selector (input select, output tick);
  modport consumer (output select, input tick);
endinterface : tick_source_if

// >>> logic/tick_edge_select.sv
// Purpose: Synchronises three clock sources and turns the chosen one's rising edges into ticks
// Assumes: Each source is slower than half of clock_i
// Notes:   First flop of each synchroniser feeds only the second
module tick_edge_select (
  // Clock and reset
  input  wire logic    clock_i,
  input  wire logic    rst_n_i,
  input  wire logic    enable_i,
  // Raw clock sources
  input  wire logic    rc_clock_i,
  input  wire logic    ext_clock_i,
  input  wire logic    osc_clock_i,
  // Selected tick
  tick_source_if.selector link
);

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] prev;
  logic [2:0] rise;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      prev   <= 3'h0;
    end else if (enable_i) begin
      sync_a <= {osc_clock_i, ext_clock_i, rc_clock_i};
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign rise = sync_b & ~prev;

  // Reserved code yields no ticks
  always_comb begin
    unique case (link.select)
      2'h0:    link.tick = rise[0];
      2'h1:    link.tick = rise[1];
      2'h2:    link.tick = rise[2];
      default: link.tick = 1'b0;
    endcase
  end

endmodule : tick_edge_select

// >>> logic/periodic_tick_unit.sv
// Purpose: Periodic interrupt generator behind an AXI4-Lite register file
// Assumes: Wait and stop modes keep clock_i and the selected source running
// Notes:   Period requests enter the keypad path like a pin event
//
// Local design decisions: the address map and register access over AXI4-Lite.
module periodic_tick_unit #(
  parameter int keypad_inputs = 4
) (
  // Clock, reset, enable
  input  wire logic                     clock_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     clk_en_i,
  // Clock sources and keypad pins
  input  wire logic                     rc_clock_i,
  input  wire logic                     ext_clock_i,
  input  wire logic                     osc_clock_i,
  input  wire logic [keypad_inputs-1:0] keypad_pins_i,
  // AXI4-Lite write address
  input  wire logic [4:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Interrupts
  output logic                          keypad_irq_o,
  output logic                          irq_o,
  // Drive enables for port B
  output logic [3:0]                    port_b_drive_o
);

  tick_source_if tick_link ();

  logic [3:0]                  drive;
  logic [1:0]                  clock_select;
  logic [2:0]                  interval_select;
  logic [keypad_inputs-1:0]    keypad_input_enables;
  logic                        keyboard_sensitivity;
  logic                        keypad_interrupt_mask;
  logic                        periodic_pending_latch;
  logic                        keypad_flag;
  logic [periodic_tick_pkg::count_width-1:0] count;
  logic [periodic_tick_pkg::count_width-1:0] period_last;
  logic                        period_hit;
  logic [keypad_inputs-1:0]    pin_a;
  logic [keypad_inputs-1:0]    pin_b;
  logic [keypad_inputs-1:0]    pin_prev;
  logic                        keypad_event;
  logic                        kb_level;
  logic [1:0]                  irq_status;
  logic [1:0]                  irq_enable;

  // Write channel capture, address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_lane0;
  logic        ack_write;
  logic        clear_write;

  assign tick_link.select = clock_select;

  tick_edge_select u_tick_select (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .enable_i    (clk_en_i),
    .rc_clock_i  (rc_clock_i),
    .ext_clock_i (ext_clock_i),
    .osc_clock_i (osc_clock_i),
    .link        (tick_link.selector)
  );

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid && clk_en_i;
  assign wr_lane0      = wr_fire && w_strb[0];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= 5'h00;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (clk_en_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= periodic_tick_pkg::resp_okay;
    end else if (clk_en_i) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr)
          periodic_tick_pkg::off_drive_clock,
          periodic_tick_pkg::off_enable_period,
          periodic_tick_pkg::off_status_ctrl,
          periodic_tick_pkg::off_irq_status,
          periodic_tick_pkg::off_irq_enable,
          periodic_tick_pkg::off_irq_clear: s_axi_bresp <= periodic_tick_pkg::resp_okay;
          default:                          s_axi_bresp <= periodic_tick_pkg::resp_slverr;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Drive and clock register; pending bit is not writable
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      drive        <= periodic_tick_pkg::rst_drive;
      clock_select <= periodic_tick_pkg::rst_clksel;
    end else if (clk_en_i && wr_lane0 && aw_addr == periodic_tick_pkg::off_drive_clock) begin
      drive        <= w_data[periodic_tick_pkg::pos_drive_lo +: 4];
      clock_select <= w_data[periodic_tick_pkg::pos_clksel_lo +: 2];
    end
  end

  assign port_b_drive_o = drive;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      interval_select      <= periodic_tick_pkg::rst_period;
      keypad_input_enables <= keypad_inputs'(periodic_tick_pkg::rst_kb_en);
    end else if (clk_en_i && wr_lane0 && aw_addr == periodic_tick_pkg::off_enable_period) begin
      interval_select      <= w_data[periodic_tick_pkg::pos_period_lo +: 3];
      keypad_input_enables <= w_data[periodic_tick_pkg::pos_kb_en_lo +: keypad_inputs];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      keyboard_sensitivity  <= 1'b0;
      keypad_interrupt_mask <= 1'b0;
    end else if (clk_en_i && wr_lane0 && aw_addr == periodic_tick_pkg::off_status_ctrl) begin
      keyboard_sensitivity  <= w_data[periodic_tick_pkg::pos_sens];
      keypad_interrupt_mask <= w_data[periodic_tick_pkg::pos_kb_mask];
    end
  end

  // Strobe is never stored, so it reads zero and is clear after reset
  assign ack_write = wr_lane0 && aw_addr == periodic_tick_pkg::off_status_ctrl
                     && w_data[periodic_tick_pkg::pos_ack];

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_enable <= periodic_tick_pkg::rst_irq_enable;
    end else if (clk_en_i && wr_lane0 && aw_addr == periodic_tick_pkg::off_irq_enable) begin
      irq_enable <= w_data[periodic_tick_pkg::num_events-1:0];
    end
  end

  assign clear_write = wr_lane0 && aw_addr == periodic_tick_pkg::off_irq_clear;

  // Period end count: 2^(8+code) counts, so last value is that minus one
  always_comb begin
    period_last = '0;
    if (interval_select != 3'h0) begin
      period_last = periodic_tick_pkg::count_width'((32'h0000_0100 << interval_select) - 32'h1);
    end
  end

  assign period_hit = tick_link.tick && interval_select != 3'h0 && count == period_last;

  // Runs off clock_i regardless of low-power mode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (clk_en_i) begin
      if (interval_select == 3'h0) begin
        count <= '0;
      end else if (tick_link.tick) begin
        if (count >= period_last) begin
          count <= '0;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      periodic_pending_latch <= 1'b0;
    end else if (clk_en_i) begin
      if (period_hit) begin
        periodic_pending_latch <= 1'b1;
      end else if (ack_write) begin
        periodic_pending_latch <= 1'b0;
      end
    end
  end

  // Keypad pin synchronisers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_a    <= '1;
      pin_b    <= '1;
      pin_prev <= '1;
    end else if (clk_en_i) begin
      pin_a    <= keypad_pins_i;
      pin_b    <= pin_a;
      pin_prev <= pin_b;
    end
  end

  // Periodic request acts as one more falling-edge source
  // Ack hides the latch term, so a single ack clears the flag in level mode too unless an enabled pin is held low
  assign kb_level     = keyboard_sensitivity
                        && ((|(~pin_b & keypad_input_enables)) || (periodic_pending_latch && !ack_write));
  assign keypad_event = (|(~pin_b & pin_prev & keypad_input_enables)) || period_hit || kb_level;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      keypad_flag <= 1'b0;
    end else if (clk_en_i) begin
      if (keypad_event) begin
        keypad_flag <= 1'b1;
      end else if (ack_write) begin
        keypad_flag <= 1'b0;
      end
    end
  end

  assign keypad_irq_o = keypad_flag && !keypad_interrupt_mask;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_status <= '0;
    end else if (clk_en_i) begin
      irq_status <= (irq_status & ~(clear_write ? w_data[1:0] : 2'h0))
                    | {keypad_event, period_hit};
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  // Read channel
  logic [31:0] rd_word;
  logic        rd_ok;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      periodic_tick_pkg::off_drive_clock: begin
        rd_word[periodic_tick_pkg::pos_pending]        = periodic_pending_latch;
        rd_word[periodic_tick_pkg::pos_drive_lo +: 4]  = drive;
        rd_word[periodic_tick_pkg::pos_clksel_lo +: 2] = clock_select;
      end
      periodic_tick_pkg::off_enable_period: begin
        rd_word[periodic_tick_pkg::pos_period_lo +: 3]            = interval_select;
        rd_word[periodic_tick_pkg::pos_kb_en_lo +: keypad_inputs] = keypad_input_enables;
      end
      periodic_tick_pkg::off_status_ctrl: begin
        rd_word[periodic_tick_pkg::pos_kb_flag] = keypad_flag;
        rd_word[periodic_tick_pkg::pos_kb_mask] = keypad_interrupt_mask;
        rd_word[periodic_tick_pkg::pos_sens]    = keyboard_sensitivity;
      end
      periodic_tick_pkg::off_irq_status: rd_word[1:0] = irq_status;
      periodic_tick_pkg::off_irq_enable: rd_word[1:0] = irq_enable;
      periodic_tick_pkg::off_irq_clear:  rd_word      = 32'h0000_0000;
      default:                           rd_ok        = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= periodic_tick_pkg::resp_okay;
    end else if (clk_en_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? periodic_tick_pkg::resp_okay : periodic_tick_pkg::resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : periodic_tick_unit

// >>> verif/tick_source_model.sv
// Purpose: Far-side stand-in: the three counting clocks and the keypad pins
// Assumes: Sources run at a quarter of clock_i
// Notes:   A stopped source rests low; released pins sit at the pull-up level
module tick_source_model (
  // Clock and controls
  input  wire logic       clock_i,
  input  wire logic [2:0] run_i,
  input  wire logic [3:0] key_low_i,
  // Sources and pins
  output logic            rc_clock_o,
  output logic            ext_clock_o,
  output logic            osc_clock_o,
  output logic [3:0]      keypad_pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase = 2'h0;
  always_ff @(posedge clock_i) begin
    phase <= phase + 2'h1;
  end
  assign rc_clock_o = run_i[0] & phase[1];
  // A quarter of the bus rate, below the half-rate limit
  assign ext_clock_o = run_i[1] & phase[1];
  assign osc_clock_o = run_i[2] & phase[1];
  assign keypad_pins_o = ~key_low_i;
endmodule : tick_source_model

// >>> verif/periodic_tick_monitor.sv
// Purpose: Bus and interrupt checks on the periodic tick unit ports
// Assumes: clk_en_i held high
// Notes:   Bound to every periodic_tick_unit instance
module periodic_tick_monitor (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Outputs
  input wire logic        keypad_irq_o,
  input wire logic        irq_o,
  input wire logic [3:0]  port_b_drive_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [4:0] rd_addr;
  always_ff @(posedge clock_i) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response open");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken with data open");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && !keypad_irq_o && port_b_drive_o == 4'h0)
    else $error("outputs busy after reset");
  a_ack_reads_zero: assert property (s_axi_rvalid && rd_addr == 5'h08 |-> !s_axi_rdata[2])
    else $error("acknowledge bit read as one");
  a_unmapped_err: assert property (s_axi_rvalid && rd_addr > 5'h14 |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_irq: cover property ($rose(irq_o));
endmodule : periodic_tick_monitor

bind periodic_tick_unit periodic_tick_monitor u_periodic_tick_monitor (.clock_i, .rst_n_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .keypad_irq_o,
  .irq_o, .port_b_drive_o);

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the periodic tick unit
// Assumes: Sources tick every four clock_i cycles
// Notes:   Bus tasks wait for the answer; the watchdog ends a hang
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [2:0]  run = 3'h0;
  logic [3:0]  key_low = 4'h0;
  logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        rc, ext, osc, awready, wready, bvalid, arready, rvalid, kirq, irq;
  logic [3:0]  pins, drive;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          miscompares = 0;
  int          num_checks = 0;

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  tick_source_model u_tick_source_model (.clock_i(clock_i), .run_i(run), .key_low_i(key_low),
    .rc_clock_o(rc), .ext_clock_o(ext), .osc_clock_o(osc), .keypad_pins_o(pins));

  periodic_tick_unit u_periodic_tick_unit (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .rc_clock_i(rc), .ext_clock_i(ext), .osc_clock_i(osc), .keypad_pins_i(pins),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .keypad_irq_o(kirq), .irq_o(irq), .port_b_drive_o(drive));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] rexp = 2'h0);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk(32'(rresp), 32'(rexp));
  endtask : rdchk

  task automatic wait_irq(input int n);
    repeat (n) begin
      @(posedge clock_i);
      if (irq === 1'b1) break;
    end
  endtask : wait_irq

  task automatic t_regs;
    rdchk(5'h00, 32'h0);
    rdchk(5'h04, 32'h0);
    rdchk(5'h08, 32'h0);
    rdchk(5'h1c, 32'h0, 2'h2);
    wr(5'h00, 32'ha8);
    chk(32'(drive), 32'ha);
    rdchk(5'h00, 32'h28);
    wr(5'h08, 32'h05);
    rdchk(5'h08, 32'h01);
    wr(5'h08, 32'h0);
    wr(5'h00, 32'h0);
  endtask : t_regs

  task automatic t_disabled;
    wr(5'h10, 32'h1);
    run <= 3'h7;
    repeat (3000) @(posedge clock_i);
    chk(32'(irq), 32'h0);
    rdchk(5'h00, 32'h0);
  endtask : t_disabled

  task automatic t_sources;
    for (int s = 0; s < 4; s++) begin
      run <= (s == 3) ? 3'h7 : 3'(1 << s);
      wr(5'h00, 32'(s));
      wr(5'h04, 32'h10);
      wait_irq(2600);
      chk(32'(irq), 32'(s < 3));
      rdchk(5'h00, (s < 3 ? 32'h80 : 32'h0) | 32'(s));
      chk(32'(kirq), 32'(s < 3));
      wr(5'h04, 32'h0);
      wr(5'h08, 32'h04);
      rdchk(5'h00, 32'(s));
      chk(32'(kirq), 32'h0);
      wr(5'h14, 32'h3);
      chk(32'(irq), 32'h0);
    end
  endtask : t_sources

  task automatic t_interval;
    time t0;
    run <= 3'h1;
    wr(5'h00, 32'h0);
    wr(5'h04, 32'h20);
    wait_irq(4400);
    t0 = $time;
    wr(5'h10, 32'h0);
    chk(32'(irq), 32'h0);
    wr(5'h10, 32'h1);
    chk(32'(irq), 32'h1);
    wr(5'h14, 32'h1);
    wait_irq(4400);
    chk(32'(($time - t0) / 20), 32'd4096);
    wr(5'h04, 32'h0);
    wr(5'h08, 32'h04);
    wr(5'h14, 32'h3);
  endtask : t_interval

  task automatic t_keypad;
    wr(5'h04, 32'h01);
    key_low <= 4'h1;
    repeat (8) @(posedge clock_i);
    chk(32'(kirq), 32'h1);
    wr(5'h08, 32'h02);
    chk(32'(kirq), 32'h0);
    wr(5'h08, 32'h05);
    rdchk(5'h08, 32'h09);
    wr(5'h04, 32'h00);
    key_low <= 4'h0;
    repeat (4) @(posedge clock_i);
    wr(5'h04, 32'h01);
    wr(5'h08, 32'h04);
    rdchk(5'h08, 32'h0);
  endtask : t_keypad

  // Periodic unit and a keypad input share the path in edge-and-level mode
  task automatic t_shared;
    run <= 3'h1;
    wr(5'h00, 32'h0);
    wr(5'h08, 32'h01);
    wr(5'h04, 32'h11);
    wait_irq(2600);
    chk(32'(kirq), 32'h1);
    rdchk(5'h00, 32'h80);
    wr(5'h04, 32'h01);
    wr(5'h08, 32'h05);
    chk(32'(kirq), 32'h0);
    rdchk(5'h00, 32'h0);
    rdchk(5'h08, 32'h01);
    wr(5'h08, 32'h0);
    wr(5'h14, 32'h3);
  endtask : t_shared

  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_disabled;
    t_sources;
    t_interval;
    t_keypad;
    t_shared;
    give_verdict;
  end

  initial begin
    #1000000;
    miscompares++;
    give_verdict;
  end
endmodule : tb_top
